// ===== core/smf_pkg.sv
// Purpose: shared constants, types and decoders for the signalling multiframe mux
// Assumes: 20 MHz system clock
// Notes: positions are zero based; position 0 is the first multiframe bit
package smf_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int FRAME_NS = 125_000;
  localparam int FRAME_CYC = (FRAME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SIG_STREAM_BPS = 8000;
  localparam int SIG_BPS = 800;
  localparam int SIG_REP = SIG_STREAM_BPS / SIG_BPS;
  localparam int RX_SAMPLE_REP = SIG_REP / 2;
  localparam int SYNC_GOOD = 3;

  // ==========================================================
  // multiframe layout
  localparam int MF_LEN = 20;
  localparam logic [4:0] POS_FAS = 5'h00;
  localparam logic [4:0] POS_ALARM = 5'h0a;
  localparam logic [4:0] POS_LAST = 5'h13;
  localparam int N_CH = 18;
  localparam logic [5:0] N_CH6 = 6'h12;
  localparam logic ALARM_NONE = 1'b1;

  // ==========================================================
  // 0.4 kbit/s rate group slots
  localparam int SLOT_MAX = 49;
  localparam logic [5:0] SLOT_2K4 = 6'h07;
  localparam logic [5:0] SLOT_4K8 = 6'h0d;
  localparam logic [5:0] SLOT_9K6 = 6'h19;
  localparam logic [5:0] SLOT_14K4 = 6'h25;
  localparam logic [5:0] SLOT_19K2 = 6'h31;

  typedef enum logic [2:0] {
    SMF_RATE_2K4 = 3'b000,
    SMF_RATE_4K8 = 3'b001,
    SMF_RATE_9K6 = 3'b010,
    SMF_RATE_14K4 = 3'b011,
    SMF_RATE_19K2 = 3'b100
  } smf_rate_t;

  // rate / 0.4 kbit/s plus one status bit
  function automatic logic [5:0] smf_slot_bits(input logic [2:0] r);
    logic [5:0] n;
    n = SLOT_2K4;
    case (r)
      SMF_RATE_4K8: n = SLOT_4K8;
      SMF_RATE_9K6: n = SLOT_9K6;
      SMF_RATE_14K4: n = SLOT_14K4;
      SMF_RATE_19K2: n = SLOT_19K2;
      default: n = SLOT_2K4;
    endcase
    return n;
  endfunction : smf_slot_bits

  // position to channel, rotated by the configured offset; both ends share it
  function automatic logic [4:0] smf_map_ch(input logic [4:0] pos, input logic [4:0] off);
    logic [5:0] c;
    c = (pos > POS_ALARM) ? ({1'b0, pos} - 6'h02) : ({1'b0, pos} - 6'h01);
    c = c + {1'b0, off};
    if (c >= (N_CH6 + N_CH6)) begin
      c = c - (N_CH6 + N_CH6);
    end else if (c >= N_CH6) begin
      c = c - N_CH6;
    end
    return c[4:0];
  endfunction : smf_map_ch

endpackage : smf_pkg

// ===== core/smf_rx_if.sv
// Purpose: carries the receive side results to the multiplexer top
// Assumes: single clock domain
// Notes: all members are driven by flip-flops in the aligner
`timescale 1ns/10ps
interface smf_rx_if;
  logic [17:0] chan;
  logic far_alarm;
  logic sync_loss;
  modport rx (output chan, output far_alarm, output sync_loss);
  modport top (input chan, input far_alarm, input sync_loss);
endinterface : smf_rx_if

// ===== core/smf_rx_align.sv
// Purpose: receive multiframe aligner and channel demultiplexer
// Assumes: rx_strobe marks one 8 kbit/s bit per 125 us user frame
// Notes: hunting slips one user frame per failed alignment check
`timescale 1ns/10ps
module smf_rx_align (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rx_bit,
  input wire logic rx_strobe,
  input wire logic [4:0] ch_offset,
  smf_rx_if.rx rxif
);
  import smf_pkg::*;

  logic [3:0] rep_q;
  logic [4:0] pos_q;
  logic fas_prev_q;
  logic [1:0] good_q;
  logic loss_q;
  logic alarm_q;
  logic [17:0] chan_q;

  // ==========================================================
  // decode
  wire step = ce && rx_strobe;
  wire sample = step && (rep_q == 4'(RX_SAMPLE_REP));
  wire at_fas = sample && (pos_q == POS_FAS);
  wire fas_ok = (rx_bit != fas_prev_q);
  wire slip = at_fas && !fas_ok && loss_q;
  wire rep_wrap = (rep_q == 4'(SIG_REP - 1));
  wire take_data = sample && !loss_q && (pos_q != POS_FAS) && (pos_q != POS_ALARM);
  wire [4:0] ch_sel = smf_map_ch(pos_q, ch_offset);

  // ==========================================================
  // bit position counter, held one frame to slip while hunting
  always_ff @(posedge clk) begin
    if (rst) begin
      rep_q <= 4'h0;
      pos_q <= 5'h00;
    end else if (step && !slip) begin // see RULE13
      rep_q <= rep_wrap ? 4'h0 : rep_q + 4'h1;
      if (rep_wrap) begin
        pos_q <= (pos_q == POS_LAST) ? POS_FAS : pos_q + 5'h01;
      end
    end
  end

  // ==========================================================
  // alignment state
  always_ff @(posedge clk) begin
    if (rst) begin
      loss_q <= 1'b1;
      good_q <= 2'h0;
      fas_prev_q <= 1'b0;
    end else if (at_fas) begin
      fas_prev_q <= rx_bit;
      if (!loss_q) begin
        loss_q <= !fas_ok; // see RULE13
      end else if (!fas_ok) begin
        good_q <= 2'h0;
      end else if (good_q == 2'(SYNC_GOOD - 1)) begin
        loss_q <= 1'b0; // see RULE13
        good_q <= 2'h0;
      end else begin
        good_q <= good_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // demultiplex; values hold while out of sync
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_q <= 1'b0;
      chan_q <= 18'h00000;
    end else begin
      if (sample && !loss_q && pos_q == POS_ALARM) begin
        alarm_q <= (rx_bit != ALARM_NONE); // see RULE9
      end
      if (take_data) begin
        chan_q[ch_sel] <= rx_bit; // see RULE4
      end
    end
  end

  assign rxif.chan = chan_q;
  assign rxif.far_alarm = alarm_q;
  assign rxif.sync_loss = loss_q;

  // ==========================================================
  // checks
  property p_rx_loss;
    @(posedge clk) disable iff (rst)
    (at_fas && !loss_q && !fas_ok) |=> loss_q;
  endproperty
  a_rx_loss: assert property (p_rx_loss) else $error("sync kept after bad alignment bit"); // see RULE13

  property p_rx_resync;
    @(posedge clk) disable iff (rst)
    (at_fas && loss_q && fas_ok && good_q == 2'h2) |=> !loss_q;
  endproperty
  a_rx_resync: assert property (p_rx_resync) else $error("no resync after good run"); // see RULE13

  property p_rx_alarm;
    @(posedge clk) disable iff (rst)
    (sample && !loss_q && pos_q == POS_ALARM) |=> (rxif.far_alarm == !$past(rx_bit));
  endproperty
  a_rx_alarm: assert property (p_rx_alarm) else $error("alarm bit decoded wrong"); // see RULE9

endmodule : smf_rx_align

// ===== core/smf_mux.sv
// Purpose: 0.8 kbit/s signalling multiframe multiplexer and demultiplexer
// Assumes: inputs synchronous to clk; peer marks each received bit with rx_strobe
// Notes: one 8 kbit/s stream bit per 125 us user frame, each signalling bit sent 10 times
// Notes on behaviour
// RULE1 - each channel control input is sampled once per 0.8 kbit/s bit time and framed.
// RULE2 - the first multiframe bit is the alignment bit, alternating 0 and 1 per multiframe.
// RULE3 - the eleventh multiframe bit is kept for the path alarm and never carries a channel.
// RULE4 - bits two to ten and twelve to twenty each carry one of eighteen channels.
// RULE5 - the alarm bit reports local loss of multiframe sync to the peer.
// RULE6 - channel to position mapping is a shared configurable offset on both ends.
// RULE7 - a 0.4 kbit/s group slot is rate over 0.4 kbit/s plus one status bit long.
// RULE8 - frame bits go out unchanged, with no inversion.
// RULE9 - the alarm bit is one with no alarm and zero while alarming.
// RULE10 - the 0.8 kbit/s stream rides in an 8 kbit/s stream placed in the user channel.
// RULE11 - the user channel frame repeats every 125 us.
// RULE12 - the slot status bit carries the ready-for-sending or control signal.
// RULE13 - the receiver counts positions modulo twenty, drops sync on a failed alternation, resyncs.
`timescale 1ns/10ps
module smf_mux #(
  parameter int FRAME_CYCLES = smf_pkg::FRAME_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [17:0] ch_ctrl_in,
  input wire logic [4:0] ch_offset,
  input wire logic rx_bit,
  input wire logic rx_strobe,
  input wire smf_pkg::smf_rate_t rate_sel,
  input wire logic [47:0] slot_info,
  input wire logic slot_ready,
  output logic tx_bit_q,
  output logic tx_strobe_q,
  output logic [17:0] ch_ctrl_out,
  output logic far_alarm,
  output logic sync_loss,
  output logic [48:0] slot_q,
  output logic [5:0] slot_len_q
);
  import smf_pkg::*;

  smf_rx_if rxif ();

  smf_rx_align u_rx (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rx_bit(rx_bit),
    .rx_strobe(rx_strobe),
    .ch_offset(ch_offset),
    .rxif(rxif)
  );

  assign ch_ctrl_out = rxif.chan;
  assign far_alarm = rxif.far_alarm;
  assign sync_loss = rxif.sync_loss;

  logic [11:0] fcnt_q;
  logic [3:0] rep_q;
  logic [4:0] pos_q;
  logic fas_q;
  logic cur_bit_q;

  // ==========================================================
  // user frame timing
  wire tick = ce && (fcnt_q == 12'h000);
  wire bit_start = tick && (rep_q == 4'h0);
  wire rep_wrap = (rep_q == 4'(SIG_REP - 1));
  wire [4:0] ch_sel = smf_map_ch(pos_q, ch_offset);
  wire alarm_bit = rxif.sync_loss ? !ALARM_NONE : ALARM_NONE;
  wire sel_bit = (pos_q == POS_FAS) ? fas_q :
                 (pos_q == POS_ALARM) ? alarm_bit : ch_ctrl_in[ch_sel]; // see RULE3
  wire cur_bit_d = bit_start ? sel_bit : cur_bit_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      fcnt_q <= 12'h000;
    end else if (ce) begin
      fcnt_q <= (fcnt_q == 12'h000) ? 12'(FRAME_CYCLES - 1) : fcnt_q - 12'h001; // see RULE11
    end
  end

  // ==========================================================
  // signalling bit sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      rep_q <= 4'h0;
      pos_q <= 5'h00;
      fas_q <= 1'b0;
    end else if (tick) begin
      rep_q <= rep_wrap ? 4'h0 : rep_q + 4'h1; // see RULE10
      if (rep_wrap) begin
        pos_q <= (pos_q == POS_LAST) ? POS_FAS : pos_q + 5'h01; // see RULE4
        if (pos_q == POS_LAST) begin
          fas_q <= !fas_q; // see RULE2
        end
      end
    end
  end

  // sampled once per signalling bit so a channel cannot change mid-bit
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_bit_q <= 1'b0;
      tx_bit_q <= 1'b0;
      tx_strobe_q <= 1'b0;
    end else if (ce) begin
      cur_bit_q <= cur_bit_d; // see RULE1
      tx_strobe_q <= tick;
      if (tick) begin
        tx_bit_q <= cur_bit_d; // see RULE8
      end
    end
  end

  // ==========================================================
  // 0.4 kbit/s slot builder: status bit first, then information bits
  logic [48:0] slot_d;
  wire [5:0] slot_len_d = smf_slot_bits(rate_sel);
  assign slot_d[0] = slot_ready; // see RULE12
  genvar gi;
  generate
    for (gi = 0; gi < SLOT_MAX - 1; gi++) begin : g_slot
      assign slot_d[gi + 1] = (6'(gi + 1) < slot_len_d) ? slot_info[gi] : 1'b0; // see RULE7
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      slot_q <= 49'h0;
      slot_len_q <= SLOT_2K4;
    end else if (ce) begin
      slot_q <= slot_d;
      slot_len_q <= slot_len_d;
    end
  end

  // ==========================================================
  // checks
  property p_frame_period;
    @(posedge clk) disable iff (rst)
    tick |=> (fcnt_q == 12'(FRAME_CYCLES - 1));
  endproperty
  a_frame_period: assert property (p_frame_period) else $error("frame reload wrong"); // see RULE11

  property p_fas_bit;
    @(posedge clk) disable iff (rst)
    (bit_start && pos_q == POS_FAS) |=> (cur_bit_q == $past(fas_q));
  endproperty
  a_fas_bit: assert property (p_fas_bit) else $error("alignment bit not sent"); // see RULE2

  property p_fas_alt;
    @(posedge clk) disable iff (rst)
    (tick && rep_wrap && pos_q == POS_LAST) |=> (fas_q != $past(fas_q));
  endproperty
  a_fas_alt: assert property (p_fas_alt) else $error("alignment bit did not alternate"); // see RULE2

  property p_alarm_bit;
    @(posedge clk) disable iff (rst)
    (bit_start && pos_q == POS_ALARM) |=> (cur_bit_q == !$past(rxif.sync_loss));
  endproperty
  a_alarm_bit: assert property (p_alarm_bit) else $error("alarm bit wrong"); // see RULE5

  property p_chan_bit;
    @(posedge clk) disable iff (rst)
    (bit_start && pos_q != POS_FAS && pos_q != POS_ALARM)
      |=> (cur_bit_q == $past(ch_ctrl_in[ch_sel]));
  endproperty
  a_chan_bit: assert property (p_chan_bit) else $error("channel bit wrong"); // see RULE6

  property p_hold;
    @(posedge clk) disable iff (rst)
    (tick && rep_q != 4'h0) |=> $stable(cur_bit_q);
  endproperty
  a_hold: assert property (p_hold) else $error("bit changed inside repeat"); // see RULE10

  property p_tx_plain;
    @(posedge clk) disable iff (rst)
    tx_strobe_q |-> (tx_bit_q == cur_bit_q);
  endproperty
  a_tx_plain: assert property (p_tx_plain) else $error("stream bit altered"); // see RULE8

  property p_slot_len;
    @(posedge clk) disable iff (rst)
    (ce && rate_sel == SMF_RATE_14K4) |=> (slot_len_q == 6'h25 && slot_q[0] == $past(slot_ready));
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong"); // see RULE7

  // freeze covers transmit and slot state; the aligner gates every update on step
  property p_ce_freeze;
    @(posedge clk) disable iff (rst)
    !ce |=> ($stable(fcnt_q) && $stable(rep_q) && $stable(pos_q) && $stable(fas_q)
      && $stable(tx_strobe_q) && $stable(tx_bit_q) && $stable(slot_q));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved"); // see RULE11

  property p_strobe_pulse;
    @(posedge clk) disable iff (rst)
    (tx_strobe_q && ce) |=> !tx_strobe_q;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long"); // see RULE11

  property p_pos_range;
    @(posedge clk) disable iff (rst)
    (pos_q <= POS_LAST) && (rep_q <= 4'(SIG_REP - 1));
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("position out of range"); // see RULE4

  property p_slot_pad;
    @(posedge clk) disable iff (rst)
    ce |=> ((slot_q >> slot_len_q) == 49'h0);
  endproperty
  a_slot_pad: assert property (p_slot_pad) else $error("slot bits above length"); // see RULE7

  property p_reset_vals;
    @(posedge clk)
    rst |=> (sync_loss && !far_alarm && ch_ctrl_out == 18'h00000 && !tx_strobe_q);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong"); // see RULE13

endmodule : smf_mux

// ===== bench/smf_peer.sv
// Purpose: peer multiplexer sending the signalling multiframe
// Assumes: one strobe every PERIOD cycles, counting starts at reset
// Notes: bad_align repeats the alignment bit to break alternation
`timescale 1ns/10ps
module smf_peer #(
  parameter int PERIOD = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [17:0] ch_ctrl,
  input wire logic [4:0] ch_offset,
  input wire logic alarm_n,
  input wire logic bad_align,
  output logic rx_bit,
  output logic rx_strobe
);
  // ==========================================================
  // framing
  int cnt;
  int rep;
  int pos;
  int ch;
  logic fas_q;
  logic bit_q;
  logic cur;
  always_comb begin
    ch = (((pos > 10) ? pos - 2 : pos - 1) + int'(ch_offset)) % 18;
    if (pos == 0) cur = fas_q;
    else if (pos == 10) cur = alarm_n;
    else cur = ch_ctrl[ch];
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
      rep <= 0;
      pos <= 0;
      fas_q <= 1'b0;
      bit_q <= 1'b0;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= (cnt == 0);
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
        bit_q <= cur;
        rep <= (rep == 9) ? 0 : rep + 1;
        if (rep == 9) begin
          pos <= (pos == 19) ? 0 : pos + 1;
          if (pos == 19 && !bad_align) fas_q <= ~fas_q;
        end
      end
    end
  end
  // between strobes the line never repeats the last bit
  assign rx_bit = rx_strobe ? bit_q : ~bit_q;
endmodule : smf_peer

// ===== bench/tb_top.sv
// Purpose: self-checking bench for the signalling multiframe mux
// Assumes: short frame parameter, peer strobes every 2 cycles
// Notes: a monitor records every transmitted stream bit
`timescale 1ns/10ps
module tb_top;
  import smf_pkg::*;
  localparam int FC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] ch_in = 18'h2d3a5;
  logic [17:0] peer_ch = 18'h1c96b;
  logic [4:0] off = 5'h03;
  smf_rate_t rate = SMF_RATE_2K4;
  logic [47:0] info = 48'h9c3a_5e71_b2d4;
  logic ready = 1'b0;
  logic alarm_n = 1'b1;
  logic bad_align = 1'b0;
  logic ce_in = 1'b1;
  logic rx_bit, rx_strobe, tx_bit_q, tx_strobe_q, far_alarm, sync_loss;
  logic [17:0] ch_out;
  logic [48:0] slot_q;
  logic [5:0] slot_len_q;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int ns = 0;
  logic tx_bits [0:3999];
  int t_str [0:1];
  always #25 clk = ~clk;

  smf_mux #(.FRAME_CYCLES(FC)) dut (.clk(clk), .rst(rst), .ce(ce_in), .ch_ctrl_in(ch_in),
    .ch_offset(off), .rx_bit(rx_bit), .rx_strobe(rx_strobe), .rate_sel(rate),
    .slot_info(info), .slot_ready(ready), .tx_bit_q(tx_bit_q), .tx_strobe_q(tx_strobe_q),
    .ch_ctrl_out(ch_out), .far_alarm(far_alarm), .sync_loss(sync_loss), .slot_q(slot_q),
    .slot_len_q(slot_len_q));
  smf_peer #(.PERIOD(2)) peer (.clk(clk), .rst(rst), .ch_ctrl(peer_ch), .ch_offset(off),
    .alarm_n(alarm_n), .bad_align(bad_align), .rx_bit(rx_bit), .rx_strobe(rx_strobe));

  // ==========================================================
  // monitor and helpers
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && tx_strobe_q === 1'b1) begin
      if (ns < 4000) tx_bits[ns] <= tx_bit_q;
      if (ns < 2) t_str[ns] <= cyc;
      ns <= ns + 1;
    end
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cycles
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  function automatic logic exp_tx(input int s);
    int p;
    p = (s % 200) / 10;
    if (p == 0) return logic'((s / 200) % 2);
    if (p == 10) return 1'b1;
    return ch_in[(((p > 10) ? p - 2 : p - 1) + int'(off)) % 18];
  endfunction : exp_tx

  // ==========================================================
  // scenarios
  task automatic t_reset;
    cycles(1);
    check("sync_loss", 64'(sync_loss), 64'(1));
    check("ch_out", 64'(ch_out), 64'(0));
  endtask : t_reset
  task automatic t_slot;
    int lens [0:4] = '{7, 13, 25, 37, 49};
    logic [48:0] e;
    for (int r = 0; r < 5; r++) begin
      rate = smf_rate_t'(r[2:0]);
      ready = r[0];
      cycles(2);
      e = '0;
      e[0] = ready;
      for (int i = 0; i < lens[r] - 1; i++) e[i + 1] = info[i];
      check("slot_len", 64'(slot_len_q), 64'(lens[r]));
      check("slot", 64'(slot_q), 64'(e));
    end
  endtask : t_slot
  task automatic t_rx_sync;
    for (int i = 0; i < 20000 && sync_loss !== 1'b0; i++) cycles(1);
    check("sync_loss", 64'(sync_loss), 64'(0));
    cycles(500);
    check("ch_out", 64'(ch_out), 64'(peer_ch));
    check("far_alarm", 64'(far_alarm), 64'(0));
  endtask : t_rx_sync
  // judged multiframe starts after sync, so the alarm bit sent is the no-alarm one
  task automatic t_tx;
    int s0;
    s0 = (ns / 200 + 1) * 200;
    for (int i = 0; i < 20000 && ns < s0 + 200; i++) cycles(1);
    check("period", 64'(t_str[1] - t_str[0]), 64'(FC));
    check("first bit", 64'(tx_bits[0]), 64'(0));
    for (int s = s0; s < s0 + 200; s++) check("tx bit", 64'(tx_bits[s]), 64'(exp_tx(s)));
  endtask : t_tx
  task automatic t_far;
    alarm_n = 1'b0;
    cycles(1200);
    check("far_alarm", 64'(far_alarm), 64'(1));
    alarm_n = 1'b1;
    cycles(1200);
    check("far_alarm", 64'(far_alarm), 64'(0));
  endtask : t_far
  task automatic t_loss;
    int s;
    bad_align = 1'b1;
    for (int i = 0; i < 3000 && sync_loss !== 1'b1; i++) cycles(1);
    check("sync_loss", 64'(sync_loss), 64'(1));
    s = (ns / 200 + 1) * 200 + 100;
    for (int i = 0; i < 20000 && ns <= s; i++) cycles(1);
    check("alarm bit", 64'(tx_bits[s]), 64'(0));
  endtask : t_loss
  // freeze just after a strobe so the held strobe level is low
  task automatic t_ce;
    int n0;
    logic [48:0] s0;
    for (int i = 0; i < 200 && tx_strobe_q !== 1'b1; i++) cycles(1);
    cycles(1);
    n0 = ns;
    s0 = slot_q;
    ce_in = 1'b0;
    rate = SMF_RATE_4K8;
    ready = 1'b1;
    cycles(3 * FC);
    check("frozen strobes", 64'(ns - n0), 64'(0));
    check("frozen slot_len", 64'(slot_len_q), 64'(SLOT_19K2));
    check("frozen slot", 64'(slot_q), 64'(s0));
    ce_in = 1'b1;
    cycles(2);
    check("slot_len", 64'(slot_len_q), 64'(SLOT_4K8));
    check("slot status", 64'(slot_q[0]), 64'(1));
    cycles(FC + 3);
    check("resumed strobes", 64'(ns - n0), 64'(1));
  endtask : t_ce

  initial begin
    #(60000 * 50);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    #2;
    rst = 1'b0;
    t_reset();
    t_slot();
    t_rx_sync();
    t_tx();
    t_far();
    t_loss();
    t_ce();
    complete_run();
  end
endmodule : tb_top
